//--- src/host_bus_pkg.sv
/*
  Constants, types and inversion helpers.
  Assumes a 25 MHz system clock; bus clock is sampled.
*/
package host_bus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned SYS_CLK_NS = 40;
  localparam int unsigned BUS_CLK_NS = 320;
  localparam int unsigned PHASES_PER_BUS_CLK = 4;
  localparam int unsigned ADDR_XFERS_PER_BUS_CLK = 2;
  localparam int unsigned PHASE_NS = BUS_CLK_NS / PHASES_PER_BUS_CLK;
  localparam int unsigned PHASE_CYCLES = (PHASE_NS / SYS_CLK_NS) < 1 ? 1 : (PHASE_NS / SYS_CLK_NS);
  localparam logic [2:0] PHASE_LAST_CYC = 3'(PHASE_CYCLES - 1);
  localparam logic [1:0] LAST_PHASE = 2'(PHASES_PER_BUS_CLK - 1);
  localparam logic [1:0] ADDR_SECOND_PHASE = 2'(PHASES_PER_BUS_CLK / ADDR_XFERS_PER_BUS_CLK);

  ////////////////////////////////////////////////////////////////////////////
  // Widths and depths
  localparam int unsigned LINE_BYTES = 64;
  localparam int unsigned LINE_OFFSET_BITS = 6;
  localparam int unsigned ADDR_BITS = 36;
  localparam int unsigned ADDR_HALF_BITS = (ADDR_BITS - LINE_OFFSET_BITS) / 2;
  localparam int unsigned DATA_BITS = 64;
  localparam int unsigned SEG_BITS = 16;
  localparam int unsigned SEGS = DATA_BITS / SEG_BITS;
  localparam int unsigned LINE_BITS = LINE_BYTES * 8;
  localparam logic [2:0] LAST_BEAT = 3'(LINE_BITS / DATA_BITS - 1);
  localparam logic [3:0] IOQ_DEPTH = 4'hC;
  localparam logic [3:0] IOQ_LAST = 4'hB;
  localparam logic [4:0] DBI_LOW_LIMIT = 5'h08;
  localparam logic [7:0] BROADCAST_ID = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer rates in MT/s
  localparam logic [10:0] DATA_RATE_200 = 11'h320;
  localparam logic [10:0] DATA_RATE_266 = 11'h42A;
  localparam logic [10:0] DATA_RATE_333 = 11'h535;
  localparam logic [9:0] ADDR_RATE = 10'h29B;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE_ARM = 2'b01,
    ST_WRITE = 2'b10,
    ST_READ = 2'b11
  } xfer_state_t;

  typedef enum logic [1:0] {
    SPEED_200 = 2'b00,
    SPEED_266 = 2'b01,
    SPEED_333 = 2'b10
  } bus_speed_t;

  typedef enum logic [1:0] {
    REDIR_PHYSICAL = 2'b00,
    REDIR_FLAT = 2'b01,
    REDIR_CLUSTER = 2'b10
  } redirect_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Returns {flag, segment as driven}
  function automatic logic [SEG_BITS:0] dbi_encode(input logic [SEG_BITS-1:0] seg);
    logic [4:0] lows;
    lows = 5'h00;
    for (int b = 0; b < SEG_BITS; b++) begin
      lows = lows + {4'h0, ~seg[b]};
    end
    if (lows > DBI_LOW_LIMIT) begin
      return {1'b1, ~seg};
    end
    return {1'b0, seg};
  endfunction

  function automatic logic [SEG_BITS-1:0] dbi_decode(input logic [SEG_BITS-1:0] seg, input logic flag);
    return flag ? ~seg : seg;
  endfunction

endpackage

//--- src/host_line_buffer.sv
/*
  Two-entry valid/ready buffer, registered outputs.
  Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module host_line_buffer #(
  parameter int unsigned WIDTH = 512
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  typedef struct packed {
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
  } buf_state_t;

  buf_state_t state;
  buf_state_t next_state;
  logic push;
  logic pop;

  always_comb begin
    next_state = state;
    push = i_in_valid & state.in_ready;
    pop = i_out_ready & state.out_valid;
    if (pop) begin
      next_state.slot0 = state.slot1;
      next_state.count = state.count - 2'h1;
    end
    if (push) begin
      if (next_state.count == 2'h0) begin
        next_state.slot0 = i_in_data;
      end else begin
        next_state.slot1 = i_in_data;
      end
      next_state.count = next_state.count + 2'h1;
    end
    next_state.out_valid = next_state.count != 2'h0;
    next_state.in_ready = next_state.count != 2'h2;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= '0;
      state.in_ready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign o_in_ready = state.in_ready;
  assign o_out_valid = state.out_valid;
  assign o_out_data = state.slot0;

endmodule

`default_nettype wire

//--- src/host_bus_port.sv
/*
  Host bus port: requests, in-order queue, one deferred read, data
  phases with inversion, interrupt match, rate report.
  Assumes asynchronous bus pins and in-order whole-line reads.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Every transfer moves one 64-byte line
// - Address sent in two halves, every other clock
// - Data four phases per clock, line in two
// - Support 200, 266 and 333 MHz rates
// - At most twelve transactions queued, plus one deferred
// - At most one deferred transaction outstanding
// - Invert data both when driving and receiving
// - Four 16-bit segments, one flag each
// - Invert segment when more than eight lines low
// - Judge each segment anew every data phase
// - Receiver undoes inversion where flag is set
// - Physical, flat and cluster interrupt redirection
module host_bus_port (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_bus_clk,
  input wire logic i_addr_strobe,
  input wire logic i_req_write,
  input wire logic [host_bus_pkg::ADDR_HALF_BITS-1:0] i_addr_half,
  input wire logic [host_bus_pkg::DATA_BITS-1:0] i_host_data_lines,
  output logic [host_bus_pkg::DATA_BITS-1:0] o_host_data_lines,
  output logic o_host_data_lines_oe,
  input wire logic [host_bus_pkg::SEGS-1:0] i_segment_invert_flags,
  output logic [host_bus_pkg::SEGS-1:0] o_segment_invert_flags,
  output logic o_segment_invert_flags_oe,
  output logic o_data_ready,
  output logic o_target_ready,
  output logic o_queue_full,
  output logic o_overflow,
  output logic o_defer_resp,
  output logic o_defer_reply,
  output logic o_req_valid,
  output logic [host_bus_pkg::ADDR_BITS-1:0] o_req_addr,
  output logic o_req_write,
  output logic o_wr_valid,
  output logic [host_bus_pkg::LINE_BITS-1:0] o_wr_line,
  input wire logic i_wr_ready,
  input wire logic i_rd_valid,
  input wire logic [host_bus_pkg::LINE_BITS-1:0] i_rd_line,
  output logic o_rd_ready,
  input wire logic [1:0] i_bus_speed,
  output logic [10:0] o_data_rate_mts,
  output logic [9:0] o_addr_rate_mts,
  input wire logic i_intr_valid,
  input wire logic [1:0] i_intr_mode,
  input wire logic [7:0] i_intr_dest,
  input wire logic [7:0] i_local_id,
  output logic o_intr_accept
);
  import host_bus_pkg::*;

  typedef struct packed {
    logic bus_clk;
    logic addr_strobe;
    logic req_write;
    logic [ADDR_HALF_BITS-1:0] addr_half;
    logic [DATA_BITS-1:0] data;
    logic [SEGS-1:0] inv;
  } pins_t;

  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    pins_t sync3;
    pins_t pin;
    logic clk_prev;
    logic [2:0] cyc;
    logic [1:0] phase;
    logic running;
    logic addr_gap;
    logic addr_pend;
    logic [ADDR_HALF_BITS-1:0] addr_hi;
    logic [11:0] q_write;
    logic [3:0] q_head;
    logic [3:0] q_tail;
    logic [3:0] q_count;
    xfer_state_t st;
    logic [2:0] beat;
    logic serving_defer;
    logic defer_pending;
    logic [LINE_BITS-1:0] line;
    logic [DATA_BITS-1:0] data_out;
    logic [SEGS-1:0] inv_out;
    logic data_oe;
    logic data_ready;
    logic target_ready;
    logic queue_full;
    logic overflow;
    logic defer_resp;
    logic defer_reply;
    logic req_valid;
    logic [ADDR_BITS-1:0] req_addr;
    logic req_write;
    logic intr_accept;
    logic [10:0] data_rate;
    logic [9:0] addr_rate;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;

  pins_t pins_now;
  logic bus_edge;
  logic tick;
  logic [1:0] tick_phase;
  logic push;
  logic pop;
  logic wbuf_push;
  logic wbuf_ready;
  logic rd_pop;
  logic rbuf_valid;
  logic [LINE_BITS-1:0] rbuf_line;
  logic [2:0] drive_idx;
  logic [DATA_BITS-1:0] rd_word;
  logic [DATA_BITS-1:0] enc_word;
  logic [SEGS-1:0] enc_flags;
  logic [DATA_BITS-1:0] dec_word;
  logic intr_match;

  assign pins_now = {i_bus_clk, i_addr_strobe, i_req_write, i_addr_half, i_host_data_lines, i_segment_invert_flags};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state = state;
    push = 1'b0;
    pop = 1'b0;
    wbuf_push = 1'b0;
    rd_pop = 1'b0;
    tick = 1'b0;
    tick_phase = 2'h0;

    // Per pin, a change counts once stages two and three agree
    next_state.sync1 = pins_now;
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    next_state.pin = (state.sync2 & state.sync3) | (state.pin & (state.sync2 ^ state.sync3));
    next_state.clk_prev = state.pin.bus_clk;
    bus_edge = state.pin.bus_clk & ~state.clk_prev;

    // Four data phases per bus clock
    if (bus_edge) begin
      next_state.cyc = 3'h0;
      next_state.phase = 2'h0;
      next_state.running = 1'b1;
      tick = 1'b1;
    end else if (state.running) begin
      if (state.cyc == PHASE_LAST_CYC) begin
        next_state.cyc = 3'h0;
        if (state.phase == LAST_PHASE) begin
          next_state.running = 1'b0;
        end else begin
          next_state.phase = state.phase + 2'h1;
          tick = 1'b1;
          tick_phase = state.phase + 2'h1;
        end
      end else begin
        next_state.cyc = state.cyc + 3'h1;
      end
    end

    // Inversion per segment, per phase, both directions
    drive_idx = (state.st == ST_READ) ? state.beat : 3'h0;
    rd_word = rbuf_line[{drive_idx, 6'h00} +: DATA_BITS];
    for (int k = 0; k < SEGS; k++) begin
      {enc_flags[k], enc_word[k*SEG_BITS +: SEG_BITS]} = dbi_encode(rd_word[k*SEG_BITS +: SEG_BITS]);
      dec_word[k*SEG_BITS +: SEG_BITS] = dbi_decode(state.pin.data[k*SEG_BITS +: SEG_BITS], state.pin.inv[k]);
    end

    // Pulses last one cycle; drive and data ready last until the next phase tick
    next_state.req_valid = 1'b0;
    next_state.overflow = 1'b0;
    next_state.defer_resp = 1'b0;
    next_state.defer_reply = 1'b0;
    if (tick) begin
      next_state.data_oe = 1'b0;
      next_state.data_ready = 1'b0;
    end

    // Address halves at edge and mid clock
    if (bus_edge) begin
      if (state.addr_gap) begin
        next_state.addr_gap = 1'b0;
      end else if (state.pin.addr_strobe) begin
        next_state.addr_hi = state.pin.addr_half;
        next_state.addr_pend = 1'b1;
        next_state.addr_gap = 1'b1;
      end
    end
    if (tick && tick_phase == ADDR_SECOND_PHASE && state.addr_pend) begin
      next_state.addr_pend = 1'b0;
      if (state.q_count < IOQ_DEPTH) begin
        push = 1'b1;
        next_state.req_valid = 1'b1;
        next_state.req_addr = {state.addr_hi, state.pin.addr_half, {LINE_OFFSET_BITS{1'b0}}};
        next_state.req_write = state.pin.req_write;
      end else begin
        next_state.overflow = 1'b1;
      end
    end

    // Data phase engine
    case (state.st)
      ST_IDLE: begin
        if (bus_edge) begin
          if (state.defer_pending && rbuf_valid) begin
            next_state.st = ST_READ;
            next_state.serving_defer = 1'b1;
            next_state.defer_pending = 1'b0;
            next_state.defer_reply = 1'b1;
          end else if (state.q_count != 4'h0 && !state.q_write[state.q_head]) begin
            if (rbuf_valid) begin
              next_state.st = ST_READ;
              next_state.serving_defer = 1'b0;
            end else if (!state.defer_pending) begin
              next_state.defer_pending = 1'b1;
              next_state.defer_resp = 1'b1;
              pop = 1'b1;
            end
          end else if (state.q_count != 4'h0 && wbuf_ready) begin
            next_state.st = ST_WRITE_ARM;
            next_state.target_ready = 1'b1;
          end
          if (next_state.st == ST_READ) begin
            next_state.data_out = enc_word;
            next_state.inv_out = enc_flags;
            next_state.data_oe = 1'b1;
            next_state.data_ready = 1'b1;
            next_state.beat = 3'h1;
          end
        end
      end
      ST_WRITE_ARM: begin
        if (bus_edge) begin
          next_state.target_ready = 1'b0;
          next_state.st = ST_WRITE;
          next_state.line[0 +: DATA_BITS] = dec_word;
          next_state.beat = 3'h1;
        end
      end
      ST_WRITE: begin
        if (tick) begin
          next_state.line[{state.beat, 6'h00} +: DATA_BITS] = dec_word;
          next_state.beat = state.beat + 3'h1;
          if (state.beat == LAST_BEAT) begin
            wbuf_push = 1'b1;
            pop = 1'b1;
            next_state.st = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        if (tick) begin
          next_state.data_out = enc_word;
          next_state.inv_out = enc_flags;
          next_state.data_oe = 1'b1;
          next_state.data_ready = 1'b1;
          next_state.beat = state.beat + 3'h1;
          if (state.beat == LAST_BEAT) begin
            rd_pop = 1'b1;
            pop = ~state.serving_defer;
            next_state.st = ST_IDLE;
          end
        end
      end
      default: begin
        next_state.st = ST_IDLE;
      end
    endcase

    // In-order queue of request kinds
    if (push) begin
      next_state.q_write[state.q_tail] = state.pin.req_write;
      next_state.q_tail = (state.q_tail == IOQ_LAST) ? 4'h0 : state.q_tail + 4'h1;
    end
    if (pop) begin
      next_state.q_head = (state.q_head == IOQ_LAST) ? 4'h0 : state.q_head + 4'h1;
    end
    next_state.q_count = state.q_count + {3'h0, push} - {3'h0, pop};
    next_state.queue_full = next_state.q_count == IOQ_DEPTH;

    // Interrupt redirection
    case (redirect_mode_t'(i_intr_mode))
      REDIR_PHYSICAL: intr_match = (i_intr_dest == i_local_id) || (i_intr_dest == BROADCAST_ID);
      REDIR_FLAT: intr_match = |(i_intr_dest & i_local_id);
      REDIR_CLUSTER: intr_match = (i_intr_dest[7:4] == i_local_id[7:4]) && |(i_intr_dest[3:0] & i_local_id[3:0]);
      default: intr_match = 1'b0;
    endcase
    next_state.intr_accept = i_intr_valid & intr_match;

    // Rate report
    case (bus_speed_t'(i_bus_speed))
      SPEED_200: next_state.data_rate = DATA_RATE_200;
      SPEED_266: next_state.data_rate = DATA_RATE_266;
      SPEED_333: next_state.data_rate = DATA_RATE_333;
      default: next_state.data_rate = DATA_RATE_200;
    endcase
    next_state.addr_rate = ADDR_RATE;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line buffers
  host_line_buffer #(.WIDTH(LINE_BITS)) wr_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(wbuf_push),
    .i_in_data(next_state.line),
    .o_in_ready(wbuf_ready),
    .o_out_valid(o_wr_valid),
    .o_out_data(o_wr_line),
    .i_out_ready(i_wr_ready)
  );

  host_line_buffer #(.WIDTH(LINE_BITS)) rd_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(i_rd_valid),
    .i_in_data(i_rd_line),
    .o_in_ready(o_rd_ready),
    .o_out_valid(rbuf_valid),
    .o_out_data(rbuf_line),
    .i_out_ready(rd_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_host_data_lines = state.data_out;
  assign o_host_data_lines_oe = state.data_oe;
  assign o_segment_invert_flags = state.inv_out;
  assign o_segment_invert_flags_oe = state.data_oe;
  assign o_data_ready = state.data_ready;
  assign o_target_ready = state.target_ready;
  assign o_queue_full = state.queue_full;
  assign o_overflow = state.overflow;
  assign o_defer_resp = state.defer_resp;
  assign o_defer_reply = state.defer_reply;
  assign o_req_valid = state.req_valid;
  assign o_req_addr = state.req_addr;
  assign o_req_write = state.req_write;
  assign o_intr_accept = state.intr_accept;
  assign o_data_rate_mts = state.data_rate;
  assign o_addr_rate_mts = state.addr_rate;

endmodule

`default_nettype wire

//--- verification/host_bus_port_properties.sv
/*
  Output checker bound to host_bus_port.
  Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_port_checker
  import host_bus_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_bus_speed,
  input wire logic [host_bus_pkg::DATA_BITS-1:0] o_host_data_lines,
  input wire logic o_host_data_lines_oe,
  input wire logic [host_bus_pkg::SEGS-1:0] o_segment_invert_flags,
  input wire logic o_data_ready,
  input wire logic o_queue_full,
  input wire logic o_overflow,
  input wire logic o_defer_resp,
  input wire logic o_defer_reply,
  input wire logic o_req_valid,
  input wire logic [host_bus_pkg::ADDR_BITS-1:0] o_req_addr,
  input wire logic [10:0] o_data_rate_mts,
  input wire logic [9:0] o_addr_rate_mts
);
  logic pend;
  logic next_pend;

  // Segment over eight lows, or eight lows flagged
  function automatic logic bad_seg(logic [63:0] d, logic [3:0] f, logic at_eight);
    int z;
    logic r;
    r = 1'b0;
    for (int s = 0; s < 4; s++) begin
      z = 0;
      for (int b = 0; b < 16; b++) begin
        z += int'(!d[16*s+b]);
      end
      r |= at_eight ? (z == 8 && f[s]) : (z > 8);
    end
    return r;
  endfunction

  function automatic logic [10:0] rate(logic [1:0] s);
    return s == 2'h1 ? 11'h42A : (s == 2'h2 ? 11'h535 : 11'h320);
  endfunction

  always_comb begin
    next_pend = pend;
    if (o_defer_resp) begin
      next_pend = 1'b1;
    end
    if (o_defer_reply) begin
      next_pend = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    pend <= i_rst ? 1'b0 : next_pend;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_burst_start;
    $rose(o_host_data_lines_oe);
  endsequence
  sequence s_four_words;
    o_data_ready [*8];
  endsequence

  a_line_aligned: assert property (o_req_valid |-> o_req_addr[5:0] == 6'h00)
    else $error("request not line aligned");
  a_addr_spacing: assert property (o_req_valid |=> !o_req_valid [*8])
    else $error("requests too close");
  a_line_burst: assert property (s_burst_start |-> s_four_words)
    else $error("read burst broken");
  a_rate_map: assert property (!$past(i_rst) |-> o_data_rate_mts == rate($past(i_bus_speed))
    && o_addr_rate_mts == 10'h29B) else $error("wrong rate report");
  a_full_overflow: assert property (o_overflow |-> o_queue_full || $past(o_queue_full))
    else $error("overflow without full queue");
  a_one_deferred: assert property (o_defer_resp |-> !pend)
    else $error("second deferral");
  a_drive_ready: assert property (o_data_ready |-> o_host_data_lines_oe)
    else $error("read word without drive");
  a_low_limit: assert property (o_data_ready |-> !bad_seg(o_host_data_lines, o_segment_invert_flags, 1'b0))
    else $error("segment over low limit");
  a_eight_plain: assert property (o_data_ready |-> !bad_seg(o_host_data_lines, o_segment_invert_flags, 1'b1))
    else $error("eight lows inverted");
endmodule

bind host_bus_port host_bus_port_checker chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bus_speed(i_bus_speed), .o_host_data_lines(o_host_data_lines),
  .o_host_data_lines_oe(o_host_data_lines_oe), .o_segment_invert_flags(o_segment_invert_flags),
  .o_data_ready(o_data_ready), .o_queue_full(o_queue_full), .o_overflow(o_overflow), .o_defer_resp(o_defer_resp),
  .o_defer_reply(o_defer_reply), .o_req_valid(o_req_valid), .o_req_addr(o_req_addr),
  .o_data_rate_mts(o_data_rate_mts), .o_addr_rate_mts(o_addr_rate_mts)
);
`default_nettype wire

//--- verification/host_cpu_model.sv
/*
  Processor model: bus clock, requests, lines.
  Assumes the bench muxes shared data wires.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic i_sys_clk,
  input wire logic i_target_ready,
  input wire logic i_data_oe,
  input wire logic i_data_ready,
  input wire logic [63:0] i_data,
  input wire logic [3:0] i_flags,
  output logic o_bus_clk,
  output logic o_strobe,
  output logic o_write,
  output logic [14:0] o_addr_half,
  output logic [63:0] o_data,
  output logic [3:0] o_flags
);
  logic [67:0] q[$];
  logic [67:0] last;
  logic have;

  initial begin
    {o_bus_clk, o_strobe, o_write, o_addr_half, o_data, o_flags} = '0;
    #17;
    forever #160 o_bus_clk = ~o_bus_clk;
  end

  function automatic logic [16:0] enc(logic [15:0] s);
    int z;
    z = 0;
    for (int b = 0; b < 16; b++) begin
      z += int'(!s[b]);
    end
    return z > 8 ? {1'b1, ~s} : {1'b0, s};
  endfunction

  // One request; next may follow two bus clocks later
  task automatic request(input logic [35:0] a, input logic w);
    @(negedge o_bus_clk);
    o_strobe = 1'b1;
    o_addr_half = a[35:21];
    @(posedge o_bus_clk);
    #120;
    o_addr_half = a[20:6];
    o_write = w;
    #180;
    o_strobe = 1'b0;
    o_addr_half = ~o_addr_half;
    o_write = ~w;
    @(posedge o_bus_clk);
  endtask

  task automatic send_line(input logic [511:0] l);
    logic [16:0] e;
    wait (i_target_ready === 1'b1);
    #137;
    for (int k = 0; k < 8; k++) begin
      for (int s = 0; s < 4; s++) begin
        e = enc(l[64*k+16*s+:16]);
        o_flags[s] = e[16];
        o_data[16*s+:16] = e[15:0];
      end
      #80;
    end
    o_data = ~o_data;
    o_flags = ~o_flags;
  endtask

  // Raw read words
  always @(posedge i_sys_clk) begin
    if (i_data_oe !== 1'b1) begin
      have <= 1'b0;
    end else if (i_data_ready === 1'b1 && (!have || {i_flags, i_data} !== last)) begin
      q.push_back({i_flags, i_data});
      last <= {i_flags, i_data};
      have <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
/*
  Bench for host_bus_port with the processor model.
  Assumes 40 ns system and 320 ns bus clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import host_bus_pkg::*;
  typedef struct {logic [1:0] sp; logic [1:0] md; logic [7:0] ds; logic [7:0] id; logic v; logic [10:0] rt; logic ac;} row_t;
  localparam logic [15:0] PAT [4] = '{16'h00FF, 16'h007F, 16'h0000, 16'hFFFF};
  row_t rows [8] = '{'{2'h0, 2'h0, 8'h05, 8'h05, 1'b1, 11'h320, 1'b1}, '{2'h1, 2'h0, 8'hFF, 8'h05, 1'b1, 11'h42A, 1'b1},
    '{2'h2, 2'h1, 8'h12, 8'h02, 1'b1, 11'h535, 1'b1}, '{2'h3, 2'h2, 8'h31, 8'h33, 1'b1, 11'h320, 1'b1},
    '{2'h0, 2'h2, 8'h41, 8'h33, 1'b1, 11'h320, 1'b0}, '{2'h1, 2'h0, 8'h05, 8'h06, 1'b1, 11'h42A, 1'b0},
    '{2'h2, 2'h3, 8'hFF, 8'hFF, 1'b1, 11'h535, 1'b0}, '{2'h0, 2'h1, 8'h12, 8'h02, 1'b0, 11'h320, 1'b0}};
  logic clk, rst, wr_ready, rd_valid, intr_valid, bus_clk, strobe, req_wr, data_oe, flags_oe, data_ready;
  logic target_ready, queue_full, overflow, defer_resp, defer_reply, req_valid, req_write, wr_valid, rd_ready, intr_accept;
  logic [1:0] speed, intr_mode;
  logic [7:0] intr_dest, local_id;
  logic [14:0] addr_half;
  logic [63:0] cpu_data, dut_data;
  logic [3:0] cpu_flags, dut_flags;
  logic [35:0] req_addr;
  logic [511:0] wr_line, rd_line;
  logic [10:0] data_rate;
  logic [9:0] addr_rate;
  int fail_count = 0, compares = 0, cycles = 0, n_acc = 0, n_ovf = 0, n_dresp = 0, n_drep = 0;

  host_bus_port dut_u (
    .i_sys_clk(clk), .i_rst(rst), .i_bus_clk(bus_clk), .i_addr_strobe(strobe), .i_req_write(req_wr),
    .i_addr_half(addr_half), .i_host_data_lines(data_oe ? dut_data : cpu_data), .o_host_data_lines(dut_data),
    .o_host_data_lines_oe(data_oe), .i_segment_invert_flags(flags_oe ? dut_flags : cpu_flags),
    .o_segment_invert_flags(dut_flags), .o_segment_invert_flags_oe(flags_oe), .o_data_ready(data_ready),
    .o_target_ready(target_ready), .o_queue_full(queue_full), .o_overflow(overflow), .o_defer_resp(defer_resp),
    .o_defer_reply(defer_reply), .o_req_valid(req_valid), .o_req_addr(req_addr), .o_req_write(req_write),
    .o_wr_valid(wr_valid), .o_wr_line(wr_line), .i_wr_ready(wr_ready), .i_rd_valid(rd_valid), .i_rd_line(rd_line),
    .o_rd_ready(rd_ready), .i_bus_speed(speed), .o_data_rate_mts(data_rate), .o_addr_rate_mts(addr_rate),
    .i_intr_valid(intr_valid), .i_intr_mode(intr_mode), .i_intr_dest(intr_dest), .i_local_id(local_id),
    .o_intr_accept(intr_accept)
  );
  host_cpu_model cpu_u (
    .i_sys_clk(clk), .i_target_ready(target_ready), .i_data_oe(data_oe), .i_data_ready(data_ready),
    .i_data(dut_data), .i_flags(dut_flags), .o_bus_clk(bus_clk), .o_strobe(strobe), .o_write(req_wr),
    .o_addr_half(addr_half), .o_data(cpu_data), .o_flags(cpu_flags)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    n_acc += req_valid === 1'b1;
    n_ovf += overflow === 1'b1;
    n_dresp += defer_resp === 1'b1;
    n_drep += defer_reply === 1'b1;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end

  function automatic logic [63:0] wd(int i, int k);
    return {PAT[(k+3)%4], PAT[(k+2)%4], PAT[(k+1)%4], PAT[k%4]} ^ 64'(i * 8 + k);
  endfunction
  function automatic logic [511:0] line(int i);
    logic [511:0] l;
    for (int k = 0; k < 8; k++) l[64*k+:64] = wd(i, k);
    return l;
  endfunction
  function automatic logic [3:0] fl(logic [63:0] w);
    logic [3:0] f;
    int z;
    for (int s = 0; s < 4; s++) begin
      z = 0;
      for (int b = 0; b < 16; b++) z += int'(!w[16*s+b]);
      f[s] = z > 8;
    end
    return f;
  endfunction

  task automatic check(input string name, input logic [511:0] seen, input logic [511:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic supply(input logic [511:0] l);
    @(negedge clk);
    rd_valid = 1'b1;
    rd_line = l;
    @(posedge clk);
    while (rd_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    rd_valid = 1'b0;
    rd_line = ~l;
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [67:0] raw;
    {rst, wr_ready, rd_valid, rd_line, speed, intr_valid, intr_mode, intr_dest, local_id} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check("reset", 512'({rd_ready, data_oe, queue_full, wr_valid, target_ready}), 512'(5'h10));
    foreach (rows[r]) begin
      {speed, intr_mode, intr_dest, local_id, intr_valid} = {rows[r].sp, rows[r].md, rows[r].ds, rows[r].id, rows[r].v};
      repeat (2) @(negedge clk);
      check("data_rate", 512'(data_rate), 512'(rows[r].rt));
      check("addr_rate", 512'(addr_rate), 512'(10'h29B));
      check("intr_accept", 512'(intr_accept), 512'(rows[r].ac));
    end
    intr_valid = 1'b0;
    cpu_u.request(36'h9ABCDE7C0, 1'b1);
    cpu_u.send_line(line(1));
    for (int n = 0; n < 400 && wr_valid !== 1'b1; n++) @(negedge clk);
    repeat (5) @(negedge clk);
    check("req_addr", 512'(req_addr), 512'(36'h9ABCDE7C0));
    check("req_write", 512'(req_write), 512'(1'b1));
    check("wr_line", wr_line, line(1));
    check("wr_stall", 512'(wr_valid), 512'(1'b1));
    wr_ready = 1'b1;
    @(negedge clk);
    wr_ready = 1'b0;
    @(negedge clk);
    check("wr_taken", 512'(wr_valid), 512'(1'b0));
    for (int r = 0; r < 14; r++) cpu_u.request(36'(r + 2) << 6, 1'b0);
    repeat (40) @(negedge clk);
    check("accepted", 512'(n_acc), 512'(14));
    check("overflow", 512'(n_ovf), 512'(1));
    check("full", 512'(queue_full), 512'(1'b1));
    check("deferred", 512'(n_dresp), 512'(1));
    for (int i = 0; i < 13; i++) supply(line(10 + i));
    for (int n = 0; n < 3000 && cpu_u.q.size() < 104; n++) @(negedge clk);
    repeat (20) @(negedge clk);
    check("reply", 512'(n_drep), 512'(1));
    check("words", 512'(cpu_u.q.size()), 512'(104));
    check("drained", 512'(queue_full), 512'(1'b0));
    foreach (cpu_u.q[n]) begin
      raw = cpu_u.q[n];
      check("rd_flags", 512'(raw[67:64]), 512'(fl(wd(10 + n / 8, n % 8))));
      check("rd_word", 512'(raw[63:0] ^ {{16{raw[67]}}, {16{raw[66]}}, {16{raw[65]}}, {16{raw[64]}}}),
        512'(wd(10 + n / 8, n % 8)));
    end
    results();
  end
endmodule
`default_nettype wire
